// >>> logic/ltc_mode_control.sv
// Purpose: per-channel transceiver mode, dominant time-out, wake detection and receive pin control
// Assumes: bus receiver level, transmit pin and supply comparators are asynchronous; chip mode is on ref_clk
// Notes:   registers are inaccessible in Forced Normal; entering Off or Fail-safe reloads defaults
`timescale 1ns/100ps

`include "ltc_consts.svh"

// Functional notes
// - control register holds per-channel slope and mode
// - slope codes keep slope; 10 drops time-out
// - mode 00 offline, 01/10 active, 11 listen
// - active codes transmit only in Normal mode
// - single channel: upper bits reserved, kept zero
// - entry to Off or Fail-safe reloads mode defaults
// - power-on: channels off, fields and wake cleared
// - Forced Normal: reads zero, channels active/off
// - Standby 11 listen, else offline, or off; Normal follows or off
// - Sleep/Reset/fail-safe offline or off; Off/Overload off
// - receive pin mirrors bus, wake low, else high
// - fail-safe entry: wake flag 0, enable 1
// - undervoltage status reads zero in Standby
// - channel count is a parameter
// - long bus low then rise: wake
// - transmit low past time-out disables transmitter
// - listen-only: transmitter off, receiver reports bus
// - forced normal config with supply: active, except in Off/Overload
module ltc_mode_control import ltc_pkg::*; #(
   parameter int NUM_CH             = 2,
   parameter int WAKE_CYCLES        = (`LTC_WAKE_FILTER_NS + `LTC_CLK_PERIOD_NS - 1) / `LTC_CLK_PERIOD_NS,
   parameter int DOM_TIMEOUT_CYCLES = (`LTC_DOM_TIMEOUT_NS + `LTC_CLK_PERIOD_NS - 1) / `LTC_CLK_PERIOD_NS
) (
   // clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   resetn,
   // chip mode and supply
   input  ltc_chip_mode_type           chipMode,
   input  wire logic                   forcedNormalConfig,
   input  wire logic                   busSupplyOkPin,
   input  wire logic                   overvoltagePin,
   // register port
   input  wire logic                   regWrEn,
   input  wire logic                   regRdEn,
   input  wire logic [7:0]             regAddr,
   input  wire logic [7:0]             regWrData,
   output logic      [7:0]             regRdData,
   // wake configuration and flags
   input  wire logic                   wakeEnWr,
   input  wire logic [NUM_CH-1:0]      wakeEnData,
   input  wire logic [NUM_CH-1:0]      wakeFlagClr,
   output logic      [NUM_CH-1:0]      channelWakeFlag,
   output logic      [NUM_CH-1:0]      channelWakeEnable,
   output logic                        busSupplyUndervoltageStatus,
   // bus side and controller pins
   input  wire logic [NUM_CH-1:0]      busRxLevel,
   input  wire logic [NUM_CH-1:0]      transmitInputPin,
   output logic      [NUM_CH-1:0]      receiveOutputPin,
   output logic      [NUM_CH-1:0]      busDominantDrive,
   output ltc_ch_state_type [NUM_CH-1:0] channelState
);

   // ==================================================
   // sizing
   localparam int MAXC = (WAKE_CYCLES > DOM_TIMEOUT_CYCLES) ? WAKE_CYCLES : DOM_TIMEOUT_CYCLES;
   localparam int CW   = $clog2(MAXC + 2);
   localparam logic [CW-1:0] WAKE_N = CW'(WAKE_CYCLES);
   localparam logic [CW-1:0] DOM_N  = CW'(DOM_TIMEOUT_CYCLES);

   // all state of the block
   typedef struct packed {
      logic [7:0]                     ctrl;      // control register
      logic [7:0]                     rdData;    // read data
      ltc_chip_mode_type              prevMode;  // mode of last cycle
      logic                           supS1;     // supply ok sync stage 1
      logic                           supS2;     // supply ok synced
      logic                           ovS1;      // overvoltage sync stage 1
      logic                           ovS2;      // overvoltage synced
      logic                           uvStat;    // undervoltage status
      logic [NUM_CH-1:0]              rxS1;      // bus level stage 1
      logic [NUM_CH-1:0]              rxS2;      // bus level synced
      logic [NUM_CH-1:0]              rxPrev;    // for edge detect
      logic [NUM_CH-1:0]              txS1;      // transmit pin stage 1
      logic [NUM_CH-1:0]              txS2;      // transmit pin synced
      logic [NUM_CH-1:0]              txPrev;    // for edge detect
      logic [NUM_CH-1:0]              txOff;     // time-out tripped
      logic [NUM_CH-1:0]              drive;     // dominant drive
      logic [NUM_CH-1:0]              rxd;       // receive pin
      logic [NUM_CH-1:0]              wakeFlag;  // wake flags
      logic [NUM_CH-1:0]              wakeEn;    // wake enables
      logic [NUM_CH-1:0][CW-1:0]      domCnt;    // dominant timer
      logic [NUM_CH-1:0][CW-1:0]      wakeCnt;   // wake low filter
      ltc_ch_state_type [NUM_CH-1:0]  chState;   // channel states
   } ltc_state_type;

   localparam ltc_state_type RST_STATE = '{
      ctrl: `LTC_CTRL_RESET, rdData: `LTC_RD_ZERO, prevMode: CM_OFF,
      supS1: 1'b0, supS2: 1'b0, ovS1: 1'b0, ovS2: 1'b0, uvStat: 1'b0,
      rxS1: '1, rxS2: '1, rxPrev: '1, txS1: '1, txS2: '1, txPrev: '1,
      txOff: '0, drive: '0, rxd: '1, wakeFlag: '0, wakeEn: '0,
      domCnt: '0, wakeCnt: '0, chState: '{default: CH_OFF}
   };

   ltc_state_type cur;   // registered state
   ltc_state_type nxt;   // next state

   // ==================================================
   // next-state logic
   always_comb begin
      logic [1:0]  modeF;
      logic [1:0]  slopeF;
      logic        fnMode;
      logic        regHit;
      logic        actCode;
      logic        tmoEn;
      logic        mirror;
      logic        wakeLow;
      logic        wakeSet;
      ltc_chip_mode_type m;
      modeF   = 2'h0;
      slopeF  = 2'h0;
      actCode = 1'b0;
      tmoEn   = 1'b0;
      mirror  = 1'b0;
      wakeLow = 1'b0;
      wakeSet = 1'b0;
      fnMode  = 1'b0;
      regHit  = 1'b0;
      m       = chipMode;
      nxt     = cur;
      // two-stage synchronisers for asynchronous levels
      nxt.supS1  = busSupplyOkPin;
      nxt.supS2  = cur.supS1;
      nxt.ovS1   = overvoltagePin;
      nxt.ovS2   = cur.ovS1;
      nxt.rxS1   = busRxLevel;
      nxt.rxS2   = cur.rxS1;
      nxt.rxPrev = cur.rxS2;
      nxt.txS1   = transmitInputPin;
      nxt.txS2   = cur.txS1;
      nxt.txPrev = cur.txS2;
      nxt.prevMode = m;
      fnMode = (m == CM_FORCED_NORMAL) || forcedNormalConfig;
      regHit = (regAddr == `LTC_CTRL_ADDR);
      // register write; upper nibble dropped on single channel
      if (regWrEn && regHit && !fnMode) begin
         nxt.ctrl = (NUM_CH > 1) ? regWrData : {4'h0, regWrData[3:0]};
      end
      // reads return zero while inaccessible or unmapped
      if (regRdEn) begin
         nxt.rdData = (regHit && !fnMode) ? cur.ctrl : `LTC_RD_ZERO;
      end
      // software wake enable and flag clear, ignored while inaccessible
      if (wakeEnWr && !fnMode) begin
         nxt.wakeEn = wakeEnData;
      end
      if (!fnMode) begin
         nxt.wakeFlag = cur.wakeFlag & ~wakeFlagClr;
      end
      // entry to Off or Fail-safe reloads that mode's defaults; other mode changes reload nothing
      if (m != cur.prevMode) begin
         if (m == CM_OFF) begin
            nxt.ctrl     = `LTC_CTRL_RESET;
            nxt.wakeFlag = '0;
            nxt.wakeEn   = '0;
         end
         if (m == CM_FAIL_SAFE) begin
            nxt.wakeFlag = '0;
            nxt.wakeEn   = '1;
         end
      end
      // standby shows the default, not the supply
      nxt.uvStat = (m == CM_STANDBY) ? 1'b0 : !cur.supS2;
      for (int i = 0; i < NUM_CH; i++) begin
         modeF   = cur.ctrl[i*`LTC_CH_FIELD_W + `LTC_MODE_LSB +: 2];
         slopeF  = cur.ctrl[i*`LTC_CH_FIELD_W + `LTC_SLOPE_LSB +: 2];
         // codes 01 and 10 both mean active
         actCode = (modeF != `LTC_MODE_OFFLINE) && (modeF != `LTC_MODE_LISTEN);
         // only code 10 drops the time-out, 11 keeps it
         tmoEn   = (slopeF != `LTC_SLOPE_NO_TIMEOUT);
         // channel state from chip mode
         if (cur.ovS2) begin
            nxt.chState[i] = CH_OFF;
         end else if (fnMode && m != CM_OFF && m != CM_OVERLOAD) begin
            nxt.chState[i] = cur.supS2 ? CH_ACTIVE : CH_OFF;
         end else begin
            unique case (m)
               CM_OFF, CM_OVERLOAD, CM_FORCED_NORMAL: nxt.chState[i] = CH_OFF;
               CM_STANDBY: nxt.chState[i] = !cur.supS2 ? CH_OFF :
                                            (modeF == `LTC_MODE_LISTEN) ? CH_LISTEN : CH_OFFLINE;
               // only normal mode makes an active code transmit
               CM_NORMAL: nxt.chState[i] = !cur.supS2 ? CH_OFF :
                                           actCode ? CH_ACTIVE :
                                           (modeF == `LTC_MODE_LISTEN) ? CH_LISTEN : CH_OFFLINE;
               CM_SLEEP, CM_RESET, CM_FAIL_SAFE: nxt.chState[i] = cur.supS2 ? CH_OFFLINE : CH_OFF;
            endcase
         end
         // dominant timer, only while transmitting is possible
         if (cur.chState[i] != CH_ACTIVE || (cur.txS2[i] && !cur.txPrev[i])) begin
            nxt.domCnt[i] = '0;
            nxt.txOff[i]  = 1'b0;
         end else if (!cur.txS2[i]) begin
            if (cur.domCnt[i] != DOM_N) begin
               nxt.domCnt[i] = cur.domCnt[i] + CW'(1);
            end
            nxt.txOff[i] = cur.txOff[i] | (tmoEn && cur.domCnt[i] == DOM_N);
         end
         // listen-only and all other states never drive
         nxt.drive[i] = (cur.chState[i] == CH_ACTIVE) && !cur.txS2[i] && !cur.txOff[i];
         // wake filter: long low, then rising edge
         if (cur.chState[i] == CH_OFFLINE && cur.wakeEn[i]) begin
            if (!cur.rxS2[i]) begin
               nxt.wakeCnt[i] = (cur.wakeCnt[i] == WAKE_N) ? WAKE_N : cur.wakeCnt[i] + CW'(1);
            end else begin
               nxt.wakeCnt[i] = '0;
               wakeSet = !cur.rxPrev[i] && (cur.wakeCnt[i] == WAKE_N);
            end
         end else begin
            nxt.wakeCnt[i] = '0;
            wakeSet = 1'b0;
         end
         // set wins over clear and over reload
         if (wakeSet) begin
            nxt.wakeFlag[i] = 1'b1;
         end
         // receive pin: mirror, wake low, or pulled up
         mirror  = (fnMode && m != CM_OFF && m != CM_OVERLOAD) || (m == CM_NORMAL && actCode) ||
                   ((m == CM_STANDBY || m == CM_NORMAL) && modeF == `LTC_MODE_LISTEN);
         wakeLow = cur.wakeFlag[i] && (m == CM_STANDBY || m == CM_RESET || m == CM_NORMAL);
         nxt.rxd[i] = mirror ? cur.rxS2[i] : !wakeLow;
      end
   end

   // ==================================================
   // state register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cur <= RST_STATE;
      end else begin
         cur <= nxt;
      end
   end

   // ==================================================
   // outputs, all from flip-flops
   assign regRdData                   = cur.rdData;
   assign channelWakeFlag             = cur.wakeFlag;
   assign channelWakeEnable           = cur.wakeEn;
   assign busSupplyUndervoltageStatus = cur.uvStat;
   assign receiveOutputPin            = cur.rxd;
   assign busDominantDrive            = cur.drive;
   assign channelState                = cur.chState;

   // ==================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence seqLongLow;
      cur.chState[0] == CH_OFFLINE && cur.wakeEn[0] && !cur.rxS2[0] && cur.wakeCnt[0] == WAKE_N;
   endsequence
   sequence seqRelease;
      cur.chState[0] == CH_OFFLINE && cur.wakeEn[0] && cur.rxS2[0] && chipMode == cur.prevMode;
   endsequence

   chk_power_on_clear: assert property (
      (chipMode == CM_OFF && cur.prevMode != CM_OFF) |=> (cur.ctrl == 8'h00 && cur.wakeEn == '0))
      else $error("off entry did not clear control and wake enables");
   chk_fn_read_zero: assert property (
      (regRdEn && (chipMode == CM_FORCED_NORMAL || forcedNormalConfig)) |=> regRdData == 8'h00)
      else $error("register read in forced normal not zero");
   chk_active_only_normal: assert property (
      (!forcedNormalConfig && chipMode != CM_NORMAL && chipMode != CM_FORCED_NORMAL) |=> channelState[0] != CH_ACTIVE)
      else $error("channel active outside normal mode");
   chk_fail_safe_entry: assert property (
      (chipMode == CM_FAIL_SAFE && cur.prevMode != CM_FAIL_SAFE) |=> (cur.wakeEn == '1))
      else $error("fail-safe entry did not enable wake detection");
   chk_listen_no_drive: assert property (
      (cur.chState[0] == CH_LISTEN) |=> !busDominantDrive[0])
      else $error("listen-only channel drove the bus");
   chk_timeout_disable: assert property (
      (cur.chState[0] == CH_ACTIVE && !cur.txS2[0] && cur.txOff[0]) |=> !busDominantDrive[0])
      else $error("transmitter not disabled after time-out");
   chk_timeout_rise_clear: assert property (
      (cur.txS2[0] && !cur.txPrev[0]) |=> !cur.txOff[0] && cur.domCnt[0] == '0)
      else $error("rising transmit edge did not reset timer");
   chk_wake_detect: assert property (
      seqLongLow ##1 seqRelease |=> cur.wakeFlag[0])
      else $error("wake pattern did not set wake flag");
   chk_wake_rx_low: assert property (
      (cur.wakeFlag[0] && chipMode == CM_STANDBY && !forcedNormalConfig &&
       cur.ctrl[1:0] != 2'h3) |=> !receiveOutputPin[0])
      else $error("receive pin not low after wake in standby");
   chk_uv_standby: assert property (
      (chipMode == CM_STANDBY) |=> !busSupplyUndervoltageStatus)
      else $error("undervoltage status not zero in standby");
   chk_single_reserved: assert property (
      (regWrEn && regAddr == `LTC_CTRL_ADDR && chipMode == cur.prevMode &&
       chipMode != CM_FORCED_NORMAL && !forcedNormalConfig) |=>
      (cur.ctrl & 8'hF0) == ($past(regWrData) & ((NUM_CH > 1) ? 8'hF0 : 8'h00)))
      else $error("upper control nibble wrong for the channel count");

endmodule // ltc_mode_control

// >>> pkg/ltc_consts.svh
// Purpose: offsets, field positions, reset values and timing for the bus transceiver mode control
// Assumes: one 8-bit control register behind the chip's serial register port
// Notes:   included by bare name; definitions only
`ifndef LTC_CONSTS_SVH
`define LTC_CONSTS_SVH

// ==================================================
// register map
`define LTC_CTRL_ADDR        8'h21
`define LTC_CTRL_RESET       8'h00
`define LTC_RD_ZERO          8'h00

// ==================================================
// field layout, per channel nibble (channel 0 in 3:0, channel 1 in 7:4)
`define LTC_CH_FIELD_W       4
`define LTC_MODE_LSB         0
`define LTC_SLOPE_LSB        2

// ==================================================
// field codes
`define LTC_MODE_OFFLINE     2'h0
`define LTC_MODE_LISTEN      2'h3
`define LTC_SLOPE_NO_TIMEOUT 2'h2

// ==================================================
// timing (clock period and filter times in ns)
`define LTC_CLK_PERIOD_NS    100
`define LTC_WAKE_FILTER_NS   50000
`define LTC_DOM_TIMEOUT_NS   20000000

`endif

// >>> pkg/ltc_pkg.sv
// Purpose: shared types of the bus transceiver mode control
// Assumes: chip operating mode comes from the chip mode controller on ref_clk
// Notes:   encodings are left to the tool
package ltc_pkg;

   // ==================================================
   // chip operating modes
   typedef enum logic [2:0] {
      CM_OFF, CM_FORCED_NORMAL, CM_STANDBY, CM_NORMAL,
      CM_SLEEP, CM_RESET, CM_OVERLOAD, CM_FAIL_SAFE
   } ltc_chip_mode_type;

   // ==================================================
   // transceiver channel states
   typedef enum logic [1:0] {
      CH_OFF, CH_OFFLINE, CH_ACTIVE, CH_LISTEN
   } ltc_ch_state_type;

endpackage

// >>> testbench/ltc_bus_partner.sv
// Purpose: far-side model of bus node and protocol controller pin
// Assumes: wired-and bus, 1 = recessive
// Notes:   remote node and transmit pin are commanded by the bench
`timescale 1ns/100ps
module ltc_bus_partner #(
   parameter int NUM_CH = 2
) (
   // bench commands
   input  wire logic [NUM_CH-1:0] remoteLow,
   input  wire logic [NUM_CH-1:0] txLow,
   // transceiver side
   input  wire logic [NUM_CH-1:0] busDominantDrive,
   output logic      [NUM_CH-1:0] busRxLevel,
   output logic      [NUM_CH-1:0] transmitInputPin
);
   // ====
   // bus goes dominant if any node pulls it low
   assign busRxLevel       = ~(busDominantDrive | remoteLow);
   // controller pin idles high, low means dominant
   assign transmitInputPin = ~txLow;
endmodule // ltc_bus_partner

// >>> testbench/lin_transceiver_mode_control_bench.sv
// Purpose: self-checking bench of the transceiver mode control
// Assumes: short wake and time-out counts set below
// Notes:   drives at falling edge; results checked from one queue
`timescale 1ns/100ps
`include "ltc_consts.svh"
module lin_transceiver_mode_control_bench import ltc_pkg::*;;
   // ====
   // stimulus and observed signals
   typedef struct packed {logic [2:0] sel; logic [7:0] exp;} ltc_note_type;
   logic ref_clk, resetn, forcedNormalConfig, busSupplyOkPin, overvoltagePin;
   logic regWrEn, regRdEn, wakeEnWr, busSupplyUndervoltageStatus;
   logic [7:0] regAddr, regWrData, regRdData, seen;
   logic [1:0] wakeEnData, wakeFlagClr, channelWakeFlag, channelWakeEnable;
   logic [1:0] busRxLevel, transmitInputPin, receiveOutputPin, busDominantDrive;
   logic [1:0] remoteLow, txLow, m0, m1, s0, s1;
   logic rdD1, rdD2, snapReq, snapD;
   ltc_chip_mode_type chipMode;
   ltc_ch_state_type [1:0] channelState;
   ltc_note_type noteQ[$];
   ltc_note_type nt;
   int errors = 0;
   int testsRun = 0;
   int cycles = 0;
   string names [7] = '{"regRdData", "channelState", "receiveOutputPin", "busDominantDrive",
                        "channelWakeFlag", "channelWakeEnable", "busSupplyUndervoltageStatus"};
   ltc_chip_mode_type mt [4] = '{CM_SLEEP, CM_RESET, CM_OVERLOAD, CM_FAIL_SAFE};
   ltc_ch_state_type  ms [4] = '{CH_OFFLINE, CH_OFFLINE, CH_OFF, CH_OFFLINE};

   // ====
   // design and far side; short counts keep the run brief
   ltc_mode_control #(.NUM_CH(2), .WAKE_CYCLES(4), .DOM_TIMEOUT_CYCLES(8)) DUT (
      .ref_clk, .resetn, .chipMode, .forcedNormalConfig, .busSupplyOkPin, .overvoltagePin,
      .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .wakeEnWr, .wakeEnData,
      .wakeFlagClr, .channelWakeFlag, .channelWakeEnable, .busSupplyUndervoltageStatus,
      .busRxLevel, .transmitInputPin, .receiveOutputPin, .busDominantDrive, .channelState);
   ltc_bus_partner #(.NUM_CH(2)) partner (
      .remoteLow, .txLow, .busDominantDrive, .busRxLevel, .transmitInputPin);

   // ====
   // clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         print_verdict();
      end
   end

   // ====
   // monitor: pops the oldest note when a result is due
   always @(posedge ref_clk) begin
      rdD1  <= regRdEn;
      rdD2  <= rdD1;
      snapD <= snapReq;
   end
   always @(negedge ref_clk) begin
      if (rdD2 || snapD) begin
         nt = noteQ.pop_front();
         case (nt.sel)
            3'h0: seen = regRdData;
            3'h1: seen = {4'h0, channelState};
            3'h2: seen = {6'h0, receiveOutputPin};
            3'h3: seen = {6'h0, busDominantDrive};
            3'h4: seen = {6'h0, channelWakeFlag};
            3'h5: seen = {6'h0, channelWakeEnable};
            default: seen = {7'h0, busSupplyUndervoltageStatus};
         endcase
         check(names[nt.sel], seen, nt.exp);
      end
   end

   // ====
   // shared tasks
   task automatic check(string nm, logic [7:0] got, logic [7:0] exp);
      testsRun++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      cyc(1);
      regWrEn = 1'b0;
      cyc(1);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      noteQ.push_back('{3'h0, e});
      regAddr = a;
      regRdEn = 1'b1;
      cyc(1);
      regRdEn = 1'b0;
      cyc(2);
   endtask
   task automatic expect_out(logic [2:0] s, logic [7:0] e);
      noteQ.push_back('{s, e});
      snapReq = 1'b1;
      cyc(1);
      snapReq = 1'b0;
      cyc(1);
   endtask
   function automatic logic [7:0] st(ltc_ch_state_type c1, ltc_ch_state_type c0);
      return {4'h0, c1, c0};
   endfunction
   // state of one channel in Normal from its mode code
   function automatic ltc_ch_state_type nm(logic [1:0] m);
      return (m == 2'h0) ? CH_OFFLINE : (m == 2'h3) ? CH_LISTEN : CH_ACTIVE;
   endfunction
   task automatic print_verdict();
      $display("checks %0d errors %0d", testsRun, errors);
      if (errors == 0 && testsRun > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ====
   // main sequence
   initial begin
      chipMode = CM_OFF;
      {forcedNormalConfig, overvoltagePin, regWrEn, regRdEn, wakeEnWr, snapReq, resetn} = 7'h0;
      {busSupplyOkPin, regAddr, regWrData} = {1'b1, `LTC_CTRL_ADDR, 8'h00};
      {wakeEnData, wakeFlagClr, remoteLow, txLow} = 8'h00;
      void'($urandom(92492));
      cyc(8);
      resetn = 1'b1;
      cyc(1);
      rd(`LTC_CTRL_ADDR, 8'h00);
      expect_out(3'h1, st(CH_OFF, CH_OFF));
      expect_out(3'h2, 8'h03);
      expect_out(3'h5, 8'h00);
      chipMode = CM_NORMAL;
      cyc(4);
      for (int i = 0; i < 4; i++) begin
         m0 = 2'(i);
         m1 = 2'(3 - i);
         s0 = 2'($urandom_range(2, 0));
         s1 = 2'($urandom_range(2, 0));
         wr(`LTC_CTRL_ADDR, {s1, m1, s0, m0});
         rd(`LTC_CTRL_ADDR, {s1, m1, s0, m0});
         expect_out(3'h1, st(nm(m1), nm(m0)));
      end
      wr(`LTC_CTRL_ADDR, 8'h31);
      remoteLow = 2'h3;
      cyc(4);
      expect_out(3'h2, 8'h00);
      remoteLow = 2'h0;
      // standby keeps the register; active code only offline
      chipMode = CM_STANDBY;
      cyc(2);
      rd(`LTC_CTRL_ADDR, 8'h31);
      expect_out(3'h1, st(CH_LISTEN, CH_OFFLINE));
      busSupplyOkPin = 1'b0;
      cyc(4);
      expect_out(3'h6, 8'h00);
      chipMode = CM_NORMAL;
      cyc(4);
      expect_out(3'h1, st(CH_OFF, CH_OFF));
      expect_out(3'h6, 8'h01);
      busSupplyOkPin = 1'b1;
      // overvoltage overrides a restored supply
      overvoltagePin = 1'b1;
      cyc(4);
      expect_out(3'h1, st(CH_OFF, CH_OFF));
      overvoltagePin = 1'b0;
      for (int i = 0; i < 4; i++) begin
         chipMode = mt[i];
         cyc(4);
         expect_out(3'h1, st(ms[i], ms[i]));
      end
      expect_out(3'h4, 8'h00);
      expect_out(3'h5, 8'h03);
      chipMode = CM_OFF;
      cyc(2);
      rd(`LTC_CTRL_ADDR, 8'h00);
      expect_out(3'h5, 8'h00);
      // forced normal: hidden register, channels active
      chipMode = CM_FORCED_NORMAL;
      wr(`LTC_CTRL_ADDR, 8'h33);
      rd(`LTC_CTRL_ADDR, 8'h00);
      expect_out(3'h1, st(CH_ACTIVE, CH_ACTIVE));
      remoteLow = 2'h2;
      cyc(4);
      expect_out(3'h2, 8'h01);
      remoteLow = 2'h0;
      busSupplyOkPin = 1'b0;
      cyc(4);
      expect_out(3'h1, st(CH_OFF, CH_OFF));
      busSupplyOkPin = 1'b1;
      chipMode = CM_STANDBY;
      forcedNormalConfig = 1'b1;
      cyc(4);
      expect_out(3'h1, st(CH_ACTIVE, CH_ACTIVE));
      forcedNormalConfig = 1'b0;
      // channel 0 times out, channel 1 has the time-out off
      chipMode = CM_NORMAL;
      wr(`LTC_CTRL_ADDR, 8'h91);
      txLow = 2'h3;
      cyc(4);
      expect_out(3'h3, 8'h03);
      cyc(20);
      expect_out(3'h3, 8'h02);
      for (int i = 0; i < 5; i++) begin
         m0 = 2'($urandom_range(3, 0));
         txLow = {m0[0], 1'b0};
         cyc(4);
         expect_out(3'h3, {6'h0, m0[0], 1'b0});
      end
      txLow = 2'h1;
      cyc(4);
      expect_out(3'h3, 8'h01);
      wr(`LTC_CTRL_ADDR, 8'h33);
      txLow = 2'h3;
      remoteLow = 2'h3;
      cyc(4);
      expect_out(3'h3, 8'h00);
      expect_out(3'h2, 8'h00);
      {txLow, remoteLow} = 4'h0;
      // wake: short low on channel 1, long low on channel 0
      chipMode = CM_STANDBY;
      wr(`LTC_CTRL_ADDR, 8'h00);
      wakeEnData = 2'h3;
      wakeEnWr = 1'b1;
      cyc(1);
      wakeEnWr = 1'b0;
      for (int k = 0; k < 2; k++) begin
         remoteLow = 2'h2;
         cyc(2);
         remoteLow = 2'h1;
         cyc(7);
         remoteLow = 2'h0;
         cyc(5);
         expect_out(3'h4, 8'h01);
         expect_out(3'h2, 8'h02);
         if (k == 0) begin
            // software clear lets the receive pin rise again
            wakeFlagClr = 2'h1;
            cyc(1);
            wakeFlagClr = 2'h0;
            cyc(2);
            expect_out(3'h2, 8'h03);
         end else begin
            // fail-safe entry drops a flag that is really set
            chipMode = CM_FAIL_SAFE;
            cyc(2);
            expect_out(3'h4, 8'h00);
         end
      end
      wr(8'h22, 8'hFF);
      rd(8'h22, 8'h00);
      rd(`LTC_CTRL_ADDR, 8'h00);
      print_verdict();
   end
endmodule // lin_transceiver_mode_control_bench
